// ---- dpr_host.sv ----
// Controller that drives a multiplexed-address DRAM module in page mode and refreshes it.
// Functional notes
// - Page mode keeps row strobe low and pulses column strobe per new column.
// - A page starts with a row latch and one full access, then column cycles.
// - Each page column cycle spans strobe active, precharge and two transitions.
// - Reads and writes may mix in any order inside one open row.
// - Refresh all 512 rows every 8 ms, one row each 15.6 us.
// - Row-only refresh: row address latched by row strobe, column strobe kept high.
// - Column strobe low before row strobe falls refreshes the internal counter row.
// - Hidden refresh: column strobe held low, row strobe precharged, then counter refresh.
// - Counter test only after at least eight counter-driven refresh cycles.
// - Counter test runs write, test read, test write, normal read, complement.
// - Wait 200 us at power-up, then eight row cycles; repeat after 4 ms idle.
`timescale 1ns/1ps
`include "dpr_map.svh"
module dpr_host #(
  parameter int unsigned INIT_WAIT_CYC = `DPR_CEIL(`DPR_PWR_WAIT_NS),
  parameter int unsigned IDLE_MAX_CYC  = `DPR_FLOOR(`DPR_IDLE_MAX_NS),
  parameter int unsigned RASP_MAX_CYC  = `DPR_FLOOR(`DPR_ROW_OPEN_MAX_NS)
) (
  input  wire logic                   clk_sys,
  input  wire logic                   resetn,
  input  wire logic                   req_valid,
  input  wire dpr_pkg::dpr_req_s      req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output dpr_pkg::dpr_rsp_s           rsp,
  input  wire logic                   refresh_en,
  input  wire logic                   refresh_cbr,
  input  wire logic                   hidden_en,
  output logic                        init_done,
  output dpr_pkg::dpr_pins_s          pins,
  input  wire logic [`DPR_DATA_W-1:0] dq_i
);
  import dpr_pkg::*;

  dpr_state_e             state_r;
  dpr_state_e             state_nxt;
  dpr_req_s               cur_r;
  dpr_req_s               sel;
  dpr_pins_s              pin_r;
  dpr_pins_s              pin_nxt;
  dpr_rsp_s               rsp_r;
  logic                   rsp_valid_r;
  logic [3:0]             tmr_r;
  logic                   tdone;
  logic                   take;
  logic                   refuse;
  logic                   ref_start;
  logic                   ref_pend_r;
  logic                   ref_due;
  logic [15:0]            refi_r;
  logic [19:0]            lng_r;
  logic [19:0]            rasp_r;
  logic                   rasp_over;
  logic [3:0]             wake_left_r;
  logic [3:0]             cbr_cnt_r;
  logic [`DPR_ROW_W-1:0]  ref_row_r;
  logic                   cyc_ct_r;
  logic                   ct_nxt;
  logic                   wake_go;

  function automatic logic [3:0] dur(input dpr_state_e st);
    case (st)
      ST_ROW:     dur = 4'(`DPR_RCD_CYC);
      ST_COL:     dur = 4'(`DPR_COL_CYC);
      ST_PAGE:    dur = 4'(`DPR_PAGE_PRE_CYC);
      ST_PRE:     dur = 4'(`DPR_RP_CYC);
      ST_HID_PRE: dur = 4'(`DPR_RP_CYC);
      ST_CBR_SET: dur = 4'(`DPR_CSR_CYC);
      ST_CBR:     dur = 4'(`DPR_CBR_CYC);
      ST_ROR:     dur = 4'(`DPR_RAS_CYC);
      default:    dur = 4'h1;
    endcase
  endfunction

  assign tdone     = (tmr_r == 4'h0);
  assign ref_due   = ref_pend_r & refresh_en;
  assign rasp_over = (rasp_r >= 20'(RASP_MAX_CYC - 2 * `DPR_PAGE_CYC));
  assign wake_go   = (state_r == ST_IDLE) && (wake_left_r != 4'h0);
  assign sel       = take ? req : cur_r;
  assign req_ready = take;
  assign rsp_valid = rsp_valid_r;
  assign rsp       = rsp_r;
  assign pins      = pin_r;
  assign init_done = (state_r != ST_PWR_WAIT) && (wake_left_r == 4'h0);

  // Sequencer: wake-up first, then due refresh, then user requests.
  always_comb begin
    state_nxt = state_r;
    take      = 1'b0;
    refuse    = 1'b0;
    ref_start = 1'b0;
    case (state_r)
      ST_PWR_WAIT: begin
        if (lng_r == 20'(INIT_WAIT_CYC - 1)) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (wake_left_r != 4'h0) begin
          state_nxt = ST_ROR;
        end else if (ref_due) begin
          ref_start = 1'b1;
          state_nxt = refresh_cbr ? ST_CBR_SET : ST_ROR;
        end else if (req_valid) begin
          take = 1'b1;
          if (req.op[1] && (cbr_cnt_r < 4'(`DPR_CT_MIN_CBR))) begin
            refuse = 1'b1;
          end else begin
            state_nxt = req.op[1] ? ST_CBR_SET : ST_ROW;
          end
        end
      end
      ST_ROW: begin
        if (tdone) begin
          state_nxt = ST_COL;
        end
      end
      ST_COL: begin
        if (tdone) begin
          if (ref_due && hidden_en && (cur_r.op == OP_RD)) begin
            ref_start = 1'b1;
            state_nxt = ST_HID_PRE;
          end else begin
            state_nxt = ST_PAGE;
          end
        end
      end
      ST_PAGE: begin
        if (tdone) begin
          // Stay in the open row only for a plain access to the same row.
          if (req_valid && !req.op[1] && (req.row == cur_r.row) && !ref_due && !rasp_over) begin
            take      = 1'b1;
            state_nxt = ST_COL;
          end else begin
            state_nxt = ST_PRE;
          end
        end
      end
      ST_PRE: begin
        if (tdone) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_CBR_SET: begin
        if (tdone) begin
          state_nxt = ST_CBR;
        end
      end
      ST_HID_PRE: begin
        if (tdone) begin
          state_nxt = ST_CBR;
        end
      end
      ST_CBR, ST_ROR: begin
        if (tdone) begin
          state_nxt = ST_PRE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  assign ct_nxt = take ? (req.op[1] & ~refuse) : (ref_start ? 1'b0 : cyc_ct_r);

  // Pin values follow the next state so every strobe leaves a flip-flop.
  always_comb begin
    pin_nxt.ras_n = 1'b1;
    pin_nxt.cas_n = 4'hF;
    pin_nxt.we_n  = 1'b1;
    pin_nxt.addr  = pin_r.addr;
    pin_nxt.dq_o  = pin_r.dq_o;
    pin_nxt.dq_oe = 1'b0;
    case (state_nxt)
      ST_ROW: begin
        pin_nxt.ras_n = 1'b0;
        pin_nxt.addr  = sel.row;
      end
      ST_COL: begin
        pin_nxt.ras_n = 1'b0;
        pin_nxt.addr  = sel.col;
        pin_nxt.cas_n = (sel.op == OP_WR) ? ~sel.be : 4'h0;
        if (sel.op == OP_WR) begin
          pin_nxt.we_n  = 1'b0;
          pin_nxt.dq_o  = sel.wdata;
          pin_nxt.dq_oe = 1'b1;
        end
      end
      ST_PAGE: pin_nxt.ras_n = 1'b0;
      ST_ROR: begin
        pin_nxt.ras_n = 1'b0;
        pin_nxt.addr  = ref_row_r;
      end
      ST_CBR_SET, ST_CBR: begin
        pin_nxt.cas_n = 4'h0;
        pin_nxt.ras_n = (state_nxt != ST_CBR);
        if (ct_nxt) begin
          pin_nxt.addr = sel.col;
          if (sel.op == OP_CT_WR) begin
            pin_nxt.we_n  = 1'b0;
            pin_nxt.dq_o  = sel.wdata;
            pin_nxt.dq_oe = 1'b1;
          end
        end
      end
      ST_HID_PRE: pin_nxt.cas_n = 4'h0;
      default: pin_nxt.ras_n = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r  <= ST_PWR_WAIT;
      cur_r    <= '0;
      cyc_ct_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cur_r    <= sel;
      cyc_ct_r <= ct_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_r <= '{ras_n: 1'b1, cas_n: 4'hF, we_n: 1'b1, addr: '0, dq_o: '0, dq_oe: 1'b0};
    end else begin
      pin_r <= pin_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tmr_r <= 4'h0;
    end else if ((state_nxt != state_r) || take) begin
      tmr_r <= dur(state_nxt) - 4'h1;
    end else if (!tdone) begin
      tmr_r <= tmr_r - 4'h1;
    end
  end

  // Read data is sampled on the last edge of the column cycle, with the column strobe still low.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rsp_valid_r <= 1'b0;
      rsp_r       <= '0;
    end else begin
      rsp_valid_r <= 1'b0;
      if (refuse) begin
        rsp_valid_r <= 1'b1;
        rsp_r.err   <= 1'b1;
      end else if (tdone && ((state_r == ST_COL) || ((state_r == ST_CBR) && cyc_ct_r))) begin
        rsp_valid_r <= 1'b1;
        rsp_r.err   <= 1'b0;
        if (!cur_r.op[0]) begin
          rsp_r.rdata <= dq_i;
        end
      end
    end
  end

  // A refresh request raised in the cycle it is served still stands.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      refi_r     <= 16'h0000;
      ref_pend_r <= 1'b0;
    end else begin
      if (refi_r == 16'(`DPR_REFI_CYC - 1)) begin
        refi_r     <= 16'h0000;
        ref_pend_r <= 1'b1;
      end else begin
        refi_r <= refi_r + 16'h0001;
        if (ref_start) begin
          ref_pend_r <= 1'b0;
        end
      end
    end
  end

  // One long counter serves the power-up pause and then the idle watchdog.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      lng_r       <= 20'h00000;
      wake_left_r <= 4'h0;
    end else begin
      if (state_r == ST_PWR_WAIT) begin
        if (lng_r == 20'(INIT_WAIT_CYC - 1)) begin
          lng_r       <= 20'h00000;
          wake_left_r <= 4'(`DPR_WAKE_CYCLES);
        end else begin
          lng_r <= lng_r + 20'h00001;
        end
      end else if (!pin_nxt.ras_n) begin
        lng_r <= 20'h00000;
      end else if (lng_r == 20'(IDLE_MAX_CYC - 1)) begin
        lng_r       <= 20'h00000;
        wake_left_r <= 4'(`DPR_WAKE_CYCLES);
      end else begin
        lng_r <= lng_r + 20'h00001;
      end
      if (wake_go) begin
        wake_left_r <= wake_left_r - 4'h1;
      end
    end
  end

  // Row-only refresh walks the rows itself; the module keeps its own counter.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ref_row_r <= '0;
      cbr_cnt_r <= 4'h0;
      rasp_r    <= 20'h00000;
    end else begin
      if ((state_r == ST_IDLE) && (state_nxt == ST_ROR)) begin
        ref_row_r <= ref_row_r + `DPR_ROW_W'(1);
      end
      if ((state_nxt == ST_CBR) && (state_r != ST_CBR) && (cbr_cnt_r < 4'(`DPR_CT_MIN_CBR))) begin
        cbr_cnt_r <= cbr_cnt_r + 4'h1;
      end
      rasp_r <= pin_r.ras_n ? 20'h00000 : rasp_r + 20'h00001;
    end
  end

endmodule

// ---- dpr_map.svh ----
// Constants for the page-mode and refresh DRAM controller: widths, counts and timing.
`ifndef DPR_MAP_SVH
`define DPR_MAP_SVH
`define DPR_ROW_W 9
`define DPR_COL_W 9
`define DPR_DATA_W 32
`define DPR_LANES 4
`define DPR_ROWS 512
`define DPR_WAKE_CYCLES 8
`define DPR_CT_MIN_CBR 8
`define DPR_CLK_NS 10
`define DPR_CEIL(ns) (((ns) + `DPR_CLK_NS - 1) / `DPR_CLK_NS)
`define DPR_FLOOR(ns) ((ns) / `DPR_CLK_NS)
`define DPR_MAX(a, b) (((a) > (b)) ? (a) : (b))
`define DPR_ROW_PRE_NS 50
`define DPR_ROW_ACT_NS 70
`define DPR_ROW_TO_COL_NS 20
`define DPR_COL_STROBE_ACTIVE_TIME_NS 20
`define DPR_COL_STROBE_PRECHARGE_TIME_NS 10
`define DPR_COL_STROBE_ACCESS_TIME_NS 20
`define DPR_ROW_STROBE_ACCESS_TIME_NS 70
`define DPR_COL_BEFORE_ROW_SETUP_TIME_NS 10
`define DPR_COL_HOLD_AFTER_ROW_NS 30
`define DPR_PAGE_CYCLE_TIME_NS 40
`define DPR_TRANSITION_NS 3
`define DPR_REFRESH_INTERVAL_NS 15600
`define DPR_PWR_WAIT_NS 200000
`define DPR_IDLE_MAX_NS 4000000
`define DPR_ROW_OPEN_MAX_NS 100000
`define DPR_COL_CYC (`DPR_MAX(`DPR_CEIL(`DPR_COL_STROBE_ACTIVE_TIME_NS), \
  `DPR_CEIL(`DPR_COL_STROBE_ACCESS_TIME_NS) + 1))
`define DPR_PAGE_CYC (`DPR_CEIL(`DPR_MAX(`DPR_PAGE_CYCLE_TIME_NS, \
  `DPR_COL_STROBE_ACTIVE_TIME_NS + `DPR_COL_STROBE_PRECHARGE_TIME_NS + 2 * `DPR_TRANSITION_NS)))
`define DPR_PAGE_PRE_CYC (`DPR_MAX(`DPR_CEIL(`DPR_COL_STROBE_PRECHARGE_TIME_NS), \
  `DPR_PAGE_CYC - `DPR_COL_CYC))
`define DPR_RCD_CYC (`DPR_MAX(`DPR_CEIL(`DPR_ROW_TO_COL_NS), \
  `DPR_CEIL(`DPR_ROW_STROBE_ACCESS_TIME_NS) + 1 - `DPR_COL_CYC))
`define DPR_RP_CYC (`DPR_CEIL(`DPR_ROW_PRE_NS))
`define DPR_RAS_CYC (`DPR_CEIL(`DPR_ROW_ACT_NS))
`define DPR_CSR_CYC (`DPR_CEIL(`DPR_COL_BEFORE_ROW_SETUP_TIME_NS))
`define DPR_CBR_CYC (`DPR_MAX(`DPR_RAS_CYC, `DPR_CEIL(`DPR_COL_HOLD_AFTER_ROW_NS)))
`define DPR_REFI_CYC (`DPR_FLOOR(`DPR_REFRESH_INTERVAL_NS))
`endif

// ---- dpr_pkg.sv ----
// Types shared by the page-mode and refresh DRAM controller.
`include "dpr_map.svh"
package dpr_pkg;
  typedef enum logic [1:0] {
    OP_RD    = 2'h0,
    OP_WR    = 2'h1,
    OP_CT_RD = 2'h2,
    OP_CT_WR = 2'h3
  } dpr_op_e;
  typedef enum logic [10:0] {
    ST_PWR_WAIT = 11'h001,
    ST_IDLE     = 11'h002,
    ST_ROW      = 11'h004,
    ST_COL      = 11'h008,
    ST_PAGE     = 11'h010,
    ST_PRE      = 11'h020,
    ST_CBR_SET  = 11'h040,
    ST_CBR      = 11'h080,
    ST_ROR      = 11'h100,
    ST_HID_PRE  = 11'h200,
    ST_SPARE    = 11'h400
  } dpr_state_e;
  typedef struct packed {
    dpr_op_e                  op;
    logic [`DPR_ROW_W-1:0]    row;
    logic [`DPR_COL_W-1:0]    col;
    logic [`DPR_DATA_W-1:0]   wdata;
    logic [`DPR_LANES-1:0]    be;
  } dpr_req_s;
  typedef struct packed {
    logic [`DPR_DATA_W-1:0]   rdata;
    logic                     err;
  } dpr_rsp_s;
  typedef struct packed {
    logic                     ras_n;
    logic [`DPR_LANES-1:0]    cas_n;
    logic                     we_n;
    logic [`DPR_ROW_W-1:0]    addr;
    logic [`DPR_DATA_W-1:0]   dq_o;
    logic                     dq_oe;
  } dpr_pins_s;
endpackage

// ---- dpr_host_chk.sv ----
// Protocol checker for the page-mode and refresh DRAM controller pins.
`timescale 1ns/1ps
module dpr_host_chk #(
  parameter int unsigned INIT_WAIT_CYC = 20
) (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire logic               rsp_valid,
  input wire dpr_pkg::dpr_rsp_s  rsp,
  input wire logic               refresh_en,
  input wire logic               init_done,
  input wire dpr_pkg::dpr_pins_s pins
);
  import dpr_pkg::*;
  logic        cas_lo;
  logic [31:0] cyc_r;
  logic [31:0] gap_r;
  logic [3:0]  wake_r;
  logic [3:0]  cbr_r;
  assign cas_lo = pins.cas_n != 4'hF;
  // The gap only counts row-strobe idle time, so long open pages do not trip it.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cyc_r <= '0;
      gap_r <= '0;
      wake_r <= '0;
      cbr_r <= '0;
    end else begin
      cyc_r <= cyc_r + 32'h1;
      gap_r <= (pins.ras_n && refresh_en) ? gap_r + 32'h1 : '0;
      // The wake count restarts whenever the block drops back into wake-up.
      if ($fell(init_done))
        wake_r <= '0;
      else if ($fell(pins.ras_n) && !$past(init_done))
        wake_r <= wake_r + 4'h1;
      if ($fell(pins.ras_n) && cas_lo && cbr_r < 4'h8)
        cbr_r <= cbr_r + 4'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence s_cas_act;
    cas_lo [*2];
  endsequence
  sequence s_ras_act;
    !pins.ras_n [*7];
  endsequence
  a_cas_width: assert property ($rose(cas_lo) |-> s_cas_act)
    else $error("column strobe pulse too short");
  a_cas_pre: assert property ($fell(cas_lo) && !pins.ras_n |-> $past(cas_lo, 3))
    else $error("page column cycle too short");
  a_row_to_col: assert property ($fell(pins.ras_n) && !cas_lo |-> !cas_lo [*2])
    else $error("column strobe too soon after row strobe");
  a_cbr_setup: assert property ($fell(pins.ras_n) && cas_lo |-> $past(cas_lo))
    else $error("column strobe setup before row strobe missing");
  a_ras_pre: assert property ($rose(pins.ras_n) |-> pins.ras_n [*5])
    else $error("row precharge too short");
  a_ras_width: assert property ($fell(pins.ras_n) |-> s_ras_act)
    else $error("row strobe pulse too short");
  a_wake_count: assert property ($rose(init_done) |=> wake_r >= 4'h8)
    else $error("ready before eight wake cycles");
  a_init_pause: assert property (
    $fell(pins.ras_n) && !init_done |-> cyc_r >= INIT_WAIT_CYC)
    else $error("row strobe during power-up pause");
  a_refresh_gap: assert property (init_done |-> gap_r < 32'h708)
    else $error("refresh interval exceeded");
  a_ct_refused: assert property (rsp_valid && rsp.err |-> cbr_r < 4'h8)
    else $error("counter test refused after enough refreshes");
  a_rsp_bound: assert property (req_valid && req_ready |-> ##[1:10] rsp_valid)
    else $error("no response to a taken request");
endmodule
bind dpr_host dpr_host_chk #(.INIT_WAIT_CYC(INIT_WAIT_CYC)) chk_u (
  .clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .refresh_en(refresh_en), .init_done(init_done),
  .pins(pins));

// ---- dpr_dram_model.sv ----
// Behavioural model of the DRAM module seen at the controller's pins.
`timescale 1ns/1ps
module dpr_dram_model (
  input  wire logic               clk_sys,
  input  wire dpr_pkg::dpr_pins_s pins,
  output logic [31:0]             dq_i
);
  import dpr_pkg::*;
  logic [31:0] mem [0:262143];
  logic [8:0]  row_r = '0, col_r = '0, ctr_r = '0;
  logic [31:0] rd_r = '0, last_r = '0;
  logic        on_r = 1'b0, ras_r = 1'b1, cas_r = 1'b0, cas_lo;
  assign cas_lo = pins.cas_n != 4'hF;
  // Released data lines show the inverse of the last word, so a stale copy never passes.
  assign dq_i = on_r ? rd_r : ~last_r;
  always @(negedge clk_sys) begin
    ras_r <= pins.ras_n;
    cas_r <= cas_lo;
    if (!cas_lo && on_r) begin
      on_r <= 1'b0;
      last_r <= rd_r;
    end
    if (cas_lo && !cas_r) begin
      col_r <= pins.addr;
      if (!pins.ras_n) begin
        rd_r <= mem[{row_r, pins.addr}];
        on_r <= pins.we_n;
      end
    end
    if (!pins.ras_n && ras_r) begin
      if (cas_lo) begin
        row_r <= ctr_r;
        ctr_r <= ctr_r + 9'h1;
        if (!on_r) begin
          rd_r <= mem[{ctr_r, col_r}];
          on_r <= pins.we_n;
        end
      end else
        row_r <= pins.addr;
    end
    if (!pins.ras_n && !ras_r && cas_lo && cas_r && !pins.we_n && pins.dq_oe)
      for (int i = 0; i < 4; i++)
        if (!pins.cas_n[i])
          mem[{row_r, col_r}][i*8 +: 8] <= pins.dq_o[i*8 +: 8];
  end
endmodule

// ---- test_dpr_host.sv ----
// Self-checking bench for the page-mode and refresh DRAM controller.
`timescale 1ns/1ps
`include "dpr_map.svh"
module test_dpr_host;
  import dpr_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, req_valid = 1'b0;
  logic        refresh_en = 1'b0, refresh_cbr = 1'b0, hidden_en = 1'b0;
  logic        req_ready, rsp_valid, init_done, ras_q = 1'b1;
  dpr_req_s    req = '0;
  dpr_rsp_s    rsp;
  dpr_pins_s   pins;
  logic [31:0] dq_i;
  logic [31:0] ref_m [int];
  logic [8:0]  bctr = '0, ct_row = '0;
  int          miscompares = 0, compares = 0, seed = 95, cbr_seen = 0;
  dpr_host #(.INIT_WAIT_CYC(20), .IDLE_MAX_CYC(3000), .RASP_MAX_CYC(100)) dut_u (
    .clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .refresh_en(refresh_en),
    .refresh_cbr(refresh_cbr), .hidden_en(hidden_en), .init_done(init_done),
    .pins(pins), .dq_i(dq_i));
  dpr_dram_model mem_u (.clk_sys(clk_sys), .pins(pins), .dq_i(dq_i));
  initial forever #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    ras_q <= pins.ras_n;
    if (ras_q && !pins.ras_n && pins.cas_n != 4'hF) begin
      ct_row <= bctr;
      bctr <= bctr + 9'h1;
      cbr_seen <= cbr_seen + 1;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic lim(input int n, input int m);
    if (n >= m) begin
      miscompares++;
      tally_and_finish;
    end
  endtask
  task automatic acc(input dpr_op_e op, input logic [8:0] r, input logic [8:0] c,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    int k;
    logic [31:0] w;
    req_valid = 1'b1;
    req = '{op, r, c, d, b};
    #1;
    for (n = 0; n < 300 && req_ready !== 1'b1; n++) begin
      @(negedge clk_sys);
      #1;
    end
    lim(n, 300);
    @(negedge clk_sys);
    req_valid = 1'b0;
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++)
      @(negedge clk_sys);
    lim(n, 20);
    k = {r, c};
    if (op[1] && cbr_seen < 8)
      chk("refused", {31'h0, rsp.err}, 32'h1);
    else begin
      chk("err", {31'h0, rsp.err}, 32'h0);
      if (op[1]) begin
        k = {ct_row, c};
        b = 4'hF;
      end
      if (op[0]) begin
        w = ref_m.exists(k) ? ref_m[k] : '0;
        for (int i = 0; i < 4; i++)
          if (b[i])
            w[i*8 +: 8] = d[i*8 +: 8];
        ref_m[k] = w;
      end else
        chk("rdata", rsp.rdata, ref_m[k]);
    end
  endtask
  initial begin
    int i, n, x;
    logic [8:0] r, c;
    repeat (8) @(negedge clk_sys);
    chk("ras idle", {31'h0, pins.ras_n}, 32'h1);
    resetn = 1'b1;
    for (n = 0; n < 2000 && init_done !== 1'b1; n++)
      @(negedge clk_sys);
    lim(n, 2000);
    acc(OP_CT_RD, 9'h0, 9'h3, '0, 4'hF);
    for (i = 0; i < 60; i++) begin
      refresh_en = i >= 20;
      x = $random(seed) & 3;
      r = ($random(seed) & 1) ? 9'h1FF : 9'h0;
      c = (x == 3) ? 9'h1FF : x[8:0];
      x = $random(seed) & 15;
      if (ref_m.exists({r, c}) && ($random(seed) & 1))
        acc(OP_RD, r, c, '0, 4'hF);
      else
        acc(OP_WR, r, c, $random(seed), (ref_m.exists({r, c}) && x) ? x[3:0] : 4'hF);
    end
    repeat (2 * `DPR_REFI_CYC + 100) @(negedge clk_sys);
    refresh_cbr = 1'b1;
    hidden_en = 1'b1;
    for (n = 0; n < 20000 && cbr_seen < 8; n++)
      @(negedge clk_sys);
    lim(n, 20000);
    for (i = 0; i < 512; i++)
      acc(OP_WR, i[8:0], 9'h5, '0, 4'hF);
    for (i = 0; i < 8; i++)
      acc(OP_CT_RD, '0, 9'h5, '0, 4'hF);
    for (i = 0; i < 8; i++)
      acc(OP_CT_WR, '0, 9'h5, '1, 4'hF);
    for (i = 0; i < 512; i++)
      acc(OP_RD, i[8:0], 9'h5, '0, 4'hF);
    tally_and_finish;
  end
endmodule
